/* File: ptx_regs.vh */
// Constants for the parallel MAC transmit capture block
`ifndef PTX_REGS_VH
`define PTX_REGS_VH

// Interface mode codes on mode_sel
`define PTX_MODE_TBI    3'h0
`define PTX_MODE_RTBI   3'h1
`define PTX_MODE_GMII   3'h2
`define PTX_MODE_MII    3'h3
`define PTX_MODE_RGMII  3'h4

// Line speed codes on speed_sel
`define PTX_SPD_10      2'h0
`define PTX_SPD_100     2'h1
`define PTX_SPD_1000    2'h2

// Captured word layout in the FIFO
`define PTX_CG_W        10
`define PTX_EN_BIT      10
`define PTX_ERR_BIT     11
`define PTX_WORD_W      12

// Reset values
`define PTX_RST_WORD    12'h000
`define PTX_RST_NIB     5'h00

// Buffer geometry
`define PTX_FIFO_DEPTH  16
`define PTX_FIFO_AW     4

`endif

/* File: ptx_capture.v */
// Parallel MAC transmit capture with output FIFO
// Operation
// - TBI: code-group bit 9 from its own pin, taken on clock rise.
// - RTBI: shared pin gives bit 4 on rise, bit 9 on fall.
// - GMII/MII: asserted error input makes error symbols at 100Mb or 1000Mb.
// - RGMII: control pin on rise is transmit enable for the data.
// - RGMII: control pin on fall is enable XOR error from the MAC.
// - RTBI: data bits 3:0 on rise, bits 8:5 on fall.
// - RGMII: data bits 3:0 on rise, bits 7:4 on fall.
// - GMII/MII: enable sampled on rise marks the data as valid.
// - GMII and TBI: all data bits captured on clock rise.
`timescale 1ns/1ps
`default_nettype none
`include "ptx_regs.vh"

////////////////////////////////////////////////////////////////////////////
module ptx_fifo #(
  parameter WIDTH = `PTX_WORD_W,
  parameter DEPTH = `PTX_FIFO_DEPTH,
  parameter AW    = `PTX_FIFO_AW
) (
  // Clock and reset
  input  wire             clock,
  input  wire             sys_rst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side, registered
  output reg              out_valid_q,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_q
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_q;
  reg  [AW-1:0]    rd_q;
  reg  [AW:0]      cnt_q;
  wire             push;
  wire             pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  // Output stage refills when empty or being taken
  assign pop      = (cnt_q != {(AW+1){1'b0}}) &&
                    (!out_valid_q || out_ready);

  always @(posedge clock) begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      wr_q        <= {AW{1'b0}};
      rd_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q  <= {WIDTH{1'b0}};
    end else begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop) begin
        rd_q       <= rd_q + 1'b1;
        out_data_q <= mem[rd_q];
      end
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
      if (pop)
        out_valid_q <= 1'b1;
      else if (out_ready)
        out_valid_q <= 1'b0;
    end
  end
endmodule // ptx_fifo

////////////////////////////////////////////////////////////////////////////
module ptx_capture (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // Configuration, same clock domain
  input  wire [2:0]  mode_sel,
  input  wire [1:0]  speed_sel,
  // MAC transmit pins
  input  wire        tx_clk_pin,
  input  wire [7:0]  tx_d_pin,
  input  wire        tx_b8_pin,
  input  wire        tx_b9_pin,
  // Captured stream
  output wire        cg_valid,
  input  wire        cg_ready,
  output wire [9:0]  cg_data,
  output wire        cg_en,
  output wire        cg_err,
  // Status
  output reg         overrun_q
);
  // Pin order: clock, bit9, bit8, data 7:0
  wire [10:0] pin_raw;
  reg  [10:0] s1_q;
  reg  [10:0] s2_q;
  reg  [10:0] s3_q;
  wire        rise;
  wire        fall;
  wire [9:0]  bus;
  reg  [4:0]  lo_q;
  reg         ctl_rise_q;
  reg  [`PTX_WORD_W-1:0] word_d;
  reg         push_d;
  reg  [`PTX_WORD_W-1:0] pend_q;
  reg         pend_v_q;
  wire        f_ready;
  wire [`PTX_WORD_W-1:0] f_out;
  wire        err_speed;

  assign pin_raw = {tx_clk_pin, tx_b9_pin, tx_b8_pin, tx_d_pin};

  // Two-flop synchronisers; third stage feeds edge and data logic only
  genvar i;
  generate
    for (i = 0; i < 11; i = i + 1) begin : g_sync
      always @(posedge clock) begin
        if (sys_rst) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= pin_raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
        end
      end
    end
  endgenerate

  // Data taken from the sample just before the edge, like a real flop
  assign rise      = s2_q[10] && !s3_q[10];
  assign fall      = !s2_q[10] && s3_q[10];
  assign bus       = s3_q[9:0];
  // No GMII/MII error symbols exist at 10Mb; RGMII errors do not depend on speed
  assign err_speed = (speed_sel == `PTX_SPD_100) ||
                     (speed_sel == `PTX_SPD_1000);

  always @* begin
    word_d = `PTX_RST_WORD;
    push_d = 1'b0;
    case (mode_sel)
      `PTX_MODE_TBI: begin
        if (rise) begin
          word_d = {1'b0, 1'b1, bus};
          push_d = 1'b1;
        end
      end
      `PTX_MODE_RTBI: begin
        if (fall) begin
          word_d = {1'b0, 1'b1, bus[9], bus[3:0], lo_q};
          push_d = 1'b1;
        end
      end
      `PTX_MODE_GMII, `PTX_MODE_MII: begin
        if (rise) begin
          word_d[7:0] = (mode_sel == `PTX_MODE_MII) ?
                        {4'h0, bus[3:0]} : bus[7:0];
          word_d[`PTX_EN_BIT]  = bus[8];
          word_d[`PTX_ERR_BIT] = bus[9] && err_speed;
          push_d = bus[8] || (bus[9] && err_speed);
        end
      end
      `PTX_MODE_RGMII: begin
        if (fall) begin
          word_d[7:0] = {bus[3:0], lo_q[3:0]};
          word_d[`PTX_EN_BIT]  = ctl_rise_q;
          word_d[`PTX_ERR_BIT] = ctl_rise_q ^ bus[9];
          push_d = ctl_rise_q || (ctl_rise_q ^ bus[9]);
        end
      end
      default: begin
        word_d = `PTX_RST_WORD;
        push_d = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      lo_q       <= `PTX_RST_NIB;
      ctl_rise_q <= 1'b0;
      pend_q     <= `PTX_RST_WORD;
      pend_v_q   <= 1'b0;
      overrun_q  <= 1'b0;
    end else begin
      if (rise) begin
        lo_q       <= {bus[9], bus[3:0]};
        ctl_rise_q <= bus[9];
      end
      // The MAC cannot be stalled; a word that finds the slot busy and the FIFO full is lost
      if (push_d && pend_v_q && !f_ready) begin
        overrun_q <= 1'b1;
      end
      if (push_d && (!pend_v_q || f_ready)) begin
        pend_q   <= word_d;
        pend_v_q <= 1'b1;
      end else if (f_ready) begin
        pend_v_q <= 1'b0;
      end
    end
  end

  ptx_fifo #(
    .WIDTH (`PTX_WORD_W),
    .DEPTH (`PTX_FIFO_DEPTH),
    .AW    (`PTX_FIFO_AW)
  ) u_fifo (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .in_valid    (pend_v_q),
    .in_ready    (f_ready),
    .in_data     (pend_q),
    .out_valid_q (cg_valid),
    .out_ready   (cg_ready),
    .out_data_q  (f_out)
  );

  assign cg_data = f_out[`PTX_CG_W-1:0];
  assign cg_en   = f_out[`PTX_EN_BIT];
  assign cg_err  = f_out[`PTX_ERR_BIT];
endmodule // ptx_capture

`default_nettype wire

/* File: ptx_capture_checker.sv */
// Assertions on the capture block's stream and status outputs
`timescale 1ns/1ps
`default_nettype none
module ptx_capture_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // Configuration
  input wire logic [2:0] mode_sel,
  input wire logic [1:0] speed_sel,
  // MAC transmit pins
  input wire logic       tx_clk_pin,
  input wire logic       tx_b8_pin,
  input wire logic       tx_b9_pin,
  input wire logic [7:0] tx_d_pin,
  // Captured stream and status
  input wire logic       cg_valid,
  input wire logic       cg_ready,
  input wire logic       cg_en,
  input wire logic       cg_err,
  input wire logic       overrun_q,
  input wire logic [9:0] cg_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_hold; cg_valid && !cg_ready |=> cg_valid && $stable(cg_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_tbi; cg_valid && mode_sel == 3'h0 |-> cg_en && !cg_err;
  endproperty
  a_tbi: assert property (p_tbi) else $error("tbi flags");
  property p_rtbi; cg_valid && mode_sel == 3'h1 |-> cg_en; endproperty
  a_rtbi: assert property (p_rtbi) else $error("rtbi flags");
  property p_idle; cg_valid && mode_sel == 3'h2 |-> cg_en || cg_err;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pushed");
  property p_mii; cg_valid && mode_sel == 3'h3 |-> cg_data[9:4] == 6'h00;
  endproperty
  a_mii: assert property (p_mii) else $error("mii width");
  property p_byte; cg_valid && mode_sel inside {3'h2, 3'h4} |->
    cg_data[9:8] == 2'h0; endproperty
  a_byte: assert property (p_byte) else $error("byte width");
  property p_rgen; cg_valid && mode_sel == 3'h4 |-> cg_en || cg_err;
  endproperty
  a_rgen: assert property (p_rgen) else $error("rgmii idle");
  property p_slow; cg_valid && mode_sel inside {3'h2, 3'h3} &&
    speed_sel == 2'h0 |-> !cg_err; endproperty
  a_slow: assert property (p_slow) else $error("10Mb error");
  property p_ovr; overrun_q |=> overrun_q; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun cleared");
endmodule // ptx_capture_checker
`default_nettype wire

/* File: ptx_mac_model.sv */
// MAC side model driving the parallel transmit pins
`timescale 1ns/1ps
`default_nettype none
module ptx_mac_model (
  // Transmit clock and pins toward the capture block
  output var logic       tx_clk_pin,
  output var logic       tx_b8_pin,
  output var logic       tx_b9_pin,
  output var logic [7:0] tx_d_pin
);
  initial {tx_clk_pin, tx_b8_pin, tx_b9_pin, tx_d_pin} = 11'h000;
  // Clock rests low between words; data centred on rise, held 20ns before and 10ns after fall
  task automatic xfer(input logic [2:0] m, input logic [9:0] w,
                      input logic en, er);
    logic [9:0] r, f;
    case (m)
      3'h1: begin
        r = {w[4], 5'h00, w[3:0]};
        f = {w[9], 5'h00, w[8:5]};
      end
      3'h2: r = {er, en, w[7:0]};
      3'h3: r = {er, en, 4'h0, w[3:0]};
      3'h4: begin
        r = {en, 5'h00, w[3:0]};
        f = {en ^ er, 5'h00, w[7:4]};
      end
      default: r = w;
    endcase
    if (m != 3'h1 && m != 3'h4) f = r;
    {tx_b9_pin, tx_b8_pin, tx_d_pin} = r;
    #20 tx_clk_pin = 1'b1;
    #20 {tx_b9_pin, tx_b8_pin, tx_d_pin} = f;
    #20 tx_clk_pin = 1'b0;
    // Scramble early so a late sample shows up; next word starts later
    #10 {tx_b9_pin, tx_b8_pin, tx_d_pin} = ~f;
    #10;
  endtask
endmodule // ptx_mac_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the transmit capture block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clock = 1'b0, sys_rst = 1'b1, cg_ready = 1'b0, rdy_on = 1'b1;
  logic [2:0] mode_sel = 3'h0;
  logic [1:0] speed_sel = 2'h2;
  logic       tx_clk_pin, tx_b8_pin, tx_b9_pin;
  logic       cg_valid, cg_en, cg_err, overrun_q;
  logic [7:0] tx_d_pin;
  logic [9:0] cg_data;
  logic [11:0] exp_q[$];
  int error_cnt = 0, num_checks = 0, cyc = 0, got = 0;
  always #5 clock = ~clock;
  ptx_mac_model mac (.tx_clk_pin, .tx_b8_pin, .tx_b9_pin, .tx_d_pin);
  ptx_capture dut (.clock, .sys_rst, .mode_sel, .speed_sel, .tx_clk_pin,
    .tx_d_pin, .tx_b8_pin, .tx_b9_pin, .cg_valid, .cg_ready, .cg_data,
    .cg_en, .cg_err, .overrun_q);
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // Bit 12 says whether the word is pushed at all
  function automatic logic [12:0] want(input logic [2:0] m,
    input logic [1:0] sp, input logic [9:0] w, input logic en, er);
    logic e;
    e = er && (m == 3'h4 || sp != 2'h0);
    case (m)
      3'h0, 3'h1: return {3'b101, w};
      3'h3: return {en | e, e, en, 6'h00, w[3:0]};
      3'h2, 3'h4: return {en | e, e, en, 2'h0, w[7:0]};
      default: return 13'h0000;
    endcase
  endfunction
  task automatic send(input int n);
    logic [9:0] w;
    logic en, er;
    logic [12:0] x;
    repeat (n) begin
      w = 10'($urandom);
      en = 1'($urandom);
      er = ($urandom_range(3) == 0);
      x = want(mode_sel, speed_sel, w, en, er);
      if (x[12]) exp_q.push_back(x[11:0]);
      mac.xfer(mode_sel, w, en, er);
    end
    repeat (40) @(posedge clock);
  endtask
  always @(negedge clock) cg_ready <= rdy_on & 1'($urandom);
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      stop_test();
    end else if (!sys_rst && cg_valid === 1'b1 && cg_ready) begin
      got++;
      if (exp_q.size() == 0) chk("extra", 12'h000, 12'hfff);
      else chk("word", exp_q.pop_front(), {cg_err, cg_en, cg_data});
    end
  end
  initial begin
    void'($urandom(42));
    repeat (4) @(posedge clock);
    @(negedge clock) sys_rst = 1'b0;
    for (int m = 0; m < 6; m++)
      for (int s = 0; s < 3; s++) begin
        @(negedge clock) mode_sel = 3'(m);
        speed_sel = 2'(s);
        send(12);
        chk("drained", 12'h000, 12'(exp_q.size()));
      end
    chk("ovr_idle", 12'h000, {11'h0, overrun_q});
    rdy_on = 1'b0;
    @(negedge clock) mode_sel = 3'h0;
    send(20);
    chk("overrun", 12'h001, {11'h0, overrun_q});
    got = 0;
    rdy_on = 1'b1;
    repeat (200) @(posedge clock);
    chk("kept", 12'h001, {11'h0, got >= 16});
    // Mid-run reset must clear the sticky flag and the buffer
    @(negedge clock) sys_rst = 1'b1;
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    chk("ovr_reset", 12'h000, {10'h0, cg_valid, overrun_q});
    exp_q.delete();
    send(4);
    chk("after_rst", 12'h000, 12'(exp_q.size()));
    stop_test();
  end
endmodule // testbench
bind ptx_capture ptx_capture_checker chk_i (.clock, .sys_rst, .mode_sel,
  .speed_sel, .tx_clk_pin, .tx_b8_pin, .tx_b9_pin, .tx_d_pin, .cg_valid,
  .cg_ready, .cg_en, .cg_err, .overrun_q, .cg_data);
`default_nettype wire
